// ==== bench/rvcb_bank_test.sv ====
// Self-checking bench for the radar control register bank.
`default_nettype none
module rvcb_bank_test
    import rvcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, ref_wave = 1'b0, sclk, sdat, le, held, mrst, calr;
    logic [31:0] p0, s9, s10, e0, e6, e7, e8, e9, e10, e11, w;
    rvcb_divide_s div, ediv;
    rvcb_refpath_s rp;
    int fails = 0, total_checks = 0, cyc = 0, rc = 0, n;
    logic [31:0] init_w [21] = '{32'h0200_0007, 32'h0000_002B, 32'h0000_000B, 32'h1D32_A64A,
        32'h2A20_B929, 32'h4000_3E88, 32'h809F_E520, 32'h011F_4827, 32'h0000_0006,
        32'h01E2_8005, 32'h0020_0004, 32'h0189_0803, 32'h0002_0642, 32'hFFF7_FFE1,
        32'h809F_E720, 32'h809F_E560, 32'h809F_ED60, 32'h809F_E5A0, 32'h809F_F5A0,
        32'h2800_B929, 32'h809F_25A0};
    int cfg [5][3] = '{'{0, 0, 1}, '{1, 0, 3}, '{0, 1, 31}, '{1, 1, 2}, '{0, 0, 7}};
    always #2 i_mclk = ~i_mclk;
    rvcb_host host (.i_mclk(i_mclk), .o_sclk(sclk), .o_sdata(sdat), .o_load_enable(le));
    rvcb_bank dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sdata(sdat),
        .i_load_enable(le), .i_reference_input(ref_wave), .o_power_cal_ctrl(p0), .o_divide(div),
        .o_refpath(rp), .o_setup_nine(s9), .o_setup_ten(s10), .o_counters_held(held),
        .o_master_reset(mrst), .o_cal_reference(calr));
    // Reference toggles every 5 cycles, a period of 10 cycles.
    always @(posedge i_mclk) begin
        rc <= (rc == 4) ? 0 : rc + 1;
        if (rc == 4) ref_wave <= ~ref_wave;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic void upd(input logic [31:0] x);
        if (e7[25] && x[4:0] != 5'h07) return;
        case (x[4:0])
            5'h00: e0 = x;
            5'h05: ediv = {x[28:17], x[16:5], e6[17:5]};
            5'h06: e6 = x;
            5'h07: e7 = x;
            5'h08: e8 = x;
            5'h09: e9 = x;
            5'h0a: e10 = x;
            5'h0b: e11 = x;
            default: ;
        endcase
        if (e7[25]) {e0, e6, e8, e9, e10, e11, ediv} = '0;
    endfunction
    // Only described fields are drawn at random; reserved bits keep the template's values.
    function automatic logic [31:0] vary(input logic [31:0] t, input logic [31:0] r);
        vary = t;
        case (t[4:0])
            5'h05: vary[28:5] = {12'(75 + int'(r[15:0]) % 4021), r[27:16]};
            5'h06: vary[17:5] = r[12:0];
            5'h07: vary[23:5] = {r[11:0], r[13:12], 5'(1 + int'(r[20:16]) % 31)};
            5'h08: vary[14:5] = r[9:0];
            5'h0b: vary[5] = r[0];
            default: ;
        endcase
    endfunction
    task automatic wr(input logic [31:0] x);
        host.send(x);
        upd(x);
        chk("power", e0, p0);
        chk("divide", ediv, div);
        chk("refpath", {e7[10], e7[11], e7[9:5], e7[23:12], e8[14:5]}, rp);
        chk("nine", e9, s9);
        chk("ten", e10, s10);
        chk("held", e11[5], held);
        chk("mreset", e7[25], mrst);
    endtask
    task automatic gap(output int k);
        k = 0;
        do begin
            @(posedge i_mclk);
            #1;
            k++;
        end while (calr !== 1'b1 && k < 1500);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {e0, e6, e7, e8, e9, e10, e11, ediv} = '0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        void'($urandom(32'h83d0));
        // Calibration waits are shortened; the bank has no timing of its own there.
        foreach (init_w[i]) wr(init_w[i]);
        $display("init sequence done");
        foreach (cfg[i]) begin
            wr({8'h01, 12'h1F4, cfg[i][1][0], cfg[i][0][0], cfg[i][2][4:0], 5'h07});
            repeat (3) gap(n);
            chk("cal period", 10 * (cfg[i][2] > 0 ? cfg[i][2] : 1) * (1 + cfg[i][1]) / (1 + cfg[i][0]), n);
        end
        wr(32'h0000_002B);
        repeat (2) gap(n);
        chk("held period", 1500, n);
        wr(32'h0000_000B);
        $display("reference path done");
        repeat (30) begin
            w = vary(init_w[$urandom_range(20, 1)], $urandom);
            wr(w);
        end
        wr(32'h0200_0007);
        wr(32'h2A20_B929);
        wr(32'h011F_4827);
        $display("random and reset done");
        close_out();
    end
endmodule // rvcb_bank_test
`default_nettype wire

// ==== bench/rvcb_checker.sv ====
// Concurrent checks on the radar control register bank ports.
`default_nettype none
module rvcb_checker
    import rvcb_pkg::*;
(
    input wire logic          i_mclk,
    input wire logic          i_rst_n,
    input wire logic          i_load_enable,
    input wire logic [31:0]   o_setup_nine,
    input wire logic [31:0]   o_setup_ten,
    input wire rvcb_divide_s  o_divide,
    input wire rvcb_refpath_s o_refpath,
    input wire logic          o_counters_held,
    input wire logic          o_master_reset,
    input wire logic          o_cal_reference
);
    // ----------------------------------------
    // Cycles since the load strobe pin
    // ----------------------------------------
    // Outputs land a few cycles after the raw pin, so a short window is allowed.
    logic [3:0] idle;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_load_enable) idle <= {3'h0, i_rst_n};
        else if (idle != 4'hf) idle <= idle + 4'h1;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_mreset_clears_regs: assert property (o_master_reset && $past(o_master_reset) |->
        o_setup_nine == 32'h0 && o_setup_ten == 32'h0) else $error("regs kept in reset");
    a_mreset_clears_div: assert property (o_master_reset && $past(o_master_reset) |->
        o_divide == '0 && o_refpath.cal_clock_divider == '0) else $error("divide kept");
    a_mreset_frees_held: assert property (o_master_reset [*2] |-> !o_counters_held)
        else $error("held bit kept in reset");
    a_mreset_no_pulse: assert property (o_master_reset [*3] |-> !o_cal_reference)
        else $error("pulse in reset");
    a_held_no_pulse: assert property (o_counters_held [*4] |-> !o_cal_reference)
        else $error("pulse while held");
    a_pulse_one_cycle: assert property (o_cal_reference |=> !o_cal_reference)
        else $error("pulse too long");
    a_regs_after_load: assert property ($changed(o_setup_nine) || $changed(o_setup_ten)
        |-> idle < 4'h8) else $error("register changed without load");
    a_div_after_load: assert property ($changed(o_divide) |-> idle < 4'h8)
        else $error("divide changed without load");
    a_ctrl_after_load: assert property ($changed(o_master_reset) || $changed(o_counters_held)
        |-> idle < 4'h8) else $error("control changed without load");
    c_mreset: cover property (o_master_reset);
    c_doubled: cover property (o_cal_reference && o_refpath.ref_doubler);
    c_held: cover property ($rose(o_counters_held));
endmodule // rvcb_checker
bind rvcb_bank rvcb_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_load_enable(i_load_enable), .o_setup_nine(o_setup_nine), .o_setup_ten(o_setup_ten),
    .o_divide(o_divide), .o_refpath(o_refpath), .o_counters_held(o_counters_held),
    .o_master_reset(o_master_reset), .o_cal_reference(o_cal_reference));
`default_nettype wire

// ==== bench/rvcb_host.sv ====
// Host model that shifts words into the serial port.
`default_nettype none
module rvcb_host (
    input  wire logic i_mclk,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_load_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_load_enable = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // The clock stands low between frames; data shows the inverse once released.
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            o_sdata <= w[i];
            o_sclk <= 1'b0;
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
        end
        o_sclk <= 1'b0;
        o_sdata <= ~w[0];
        tick(4);
        o_load_enable <= 1'b1;
        tick(4);
        o_load_enable <= 1'b0;
        tick(8);
    endtask
endmodule // rvcb_host
`default_nettype wire

// ==== hw/rvcb_bank.sv ====
// Serial-loaded control register bank with master and counter reset.
`include "rvcb_defs.svh"
`default_nettype none

// How it works
// - Fraction is R5 bits 16..5 above fraction-low bits 17..5, 25 bits.
// - Select 00110 loads fraction-low, 00111 reset-reference, 01000 cal-clock.
// - Select 01001 loads register nine, 01010 ten, 01011 counter-reset.
// - Master reset bit 25 clears device and registers; zero resumes.
// - Reset-reference bits 23..12 hold calibration divider; host targets 10 us.
// - Bit 11 adds a divide-by-two toggle before the calibration block.
// - Bit 10 zero passes reference straight; one doubles it first.
// - Five-bit reference counter makes calibration reference; host uses 1..31.
// - Cal-clock bits 14..5 hold calibration clock divider; host targets 10 us.
// - Counter-reset bit 5 holds internal counters in reset until cleared.
// - Select 00000 loads register zero.
// - Double-buffered fields take effect only on the next register five write.
// - Register five bits 28..17 hold integer divide; host uses 75..4095.
module rvcb_bank
    import rvcb_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_sclk,
    input  wire logic         i_sdata,
    input  wire logic         i_load_enable,
    input  wire logic         i_reference_input,
    output logic [31:0]       o_power_cal_ctrl,
    output rvcb_divide_s      o_divide,
    output rvcb_refpath_s     o_refpath,
    output logic [31:0]       o_setup_nine,
    output logic [31:0]       o_setup_ten,
    output logic              o_counters_held,
    output logic              o_master_reset,
    output logic              o_cal_reference
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sclk_sync;
    logic [1:0] le_sync;
    logic [1:0] sdata_sync;
    logic [1:0] ref_sync;
    logic       sclk_last;
    logic       le_last;
    logic       ref_last;

    always_ff @(posedge i_mclk) begin
        sclk_sync  <= {sclk_sync[0], i_sclk};
        le_sync    <= {le_sync[0], i_load_enable};
        sdata_sync <= {sdata_sync[0], i_sdata};
        ref_sync   <= {ref_sync[0], i_reference_input};
        sclk_last  <= sclk_sync[1];
        le_last    <= le_sync[1];
        ref_last   <= ref_sync[1];
    end

    logic sclk_rise;
    logic le_rise;
    logic ref_edge;
    logic ref_rise;
    assign sclk_rise = sclk_sync[1] & ~sclk_last;
    assign le_rise   = le_sync[1] & ~le_last;
    assign ref_rise  = ref_sync[1] & ~ref_last;
    assign ref_edge  = ref_sync[1] ^ ref_last;

    // ------------------------------------------------------------------
    // Shift register and word latch
    // ------------------------------------------------------------------
    logic [31:0] shift_word;
    logic        master_reset;
    logic        sync_reset;

    assign sync_reset = ~i_rst_n | master_reset;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            shift_word <= `RVCB_WORD_RESET;
        end else if (sclk_rise) begin
            shift_word <= {shift_word[30:0], sdata_sync[1]};
        end
    end

    logic [4:0] sel;
    assign sel = shift_word[4:0];

    function automatic logic hit(input logic [4:0] code);
        hit = le_rise && (sel == code);
    endfunction

    logic [31:0] fraction_low_reg;
    logic [31:0] reset_reference_reg;
    logic [31:0] cal_clock_divider_reg;
    logic [31:0] reserved_setup_nine_reg;
    logic [31:0] reserved_setup_ten_reg;
    logic [31:0] counter_reset_reg;
    logic [31:0] power_cal_reg;
    logic [31:0] int_frac_reg;

    // The master reset word itself must still land, so bit 25 can later be cleared.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            reset_reference_reg <= `RVCB_WORD_RESET;
        end else if (hit(`RVCB_SEL_RESET_REF)) begin
            reset_reference_reg <= shift_word;
        end else if (master_reset) begin
            reset_reference_reg[31:0] <= {6'h00, 1'b1, 25'h000_0000};
        end
    end
    assign master_reset = reset_reference_reg[`RVCB_MASTER_RESET_BIT];

    always_ff @(posedge i_mclk) begin
        if (sync_reset) begin
            fraction_low_reg        <= `RVCB_WORD_RESET;
            cal_clock_divider_reg   <= `RVCB_WORD_RESET;
            reserved_setup_nine_reg <= `RVCB_WORD_RESET;
            reserved_setup_ten_reg  <= `RVCB_WORD_RESET;
            counter_reset_reg       <= `RVCB_WORD_RESET;
            power_cal_reg           <= `RVCB_WORD_RESET;
            int_frac_reg            <= `RVCB_WORD_RESET;
        end else begin
            if (hit(`RVCB_SEL_FRAC_LOW))   fraction_low_reg        <= shift_word;
            if (hit(`RVCB_SEL_CAL_CLOCK))  cal_clock_divider_reg   <= shift_word;
            if (hit(`RVCB_SEL_SETUP_NINE)) reserved_setup_nine_reg <= shift_word;
            if (hit(`RVCB_SEL_SETUP_TEN))  reserved_setup_ten_reg  <= shift_word;
            if (hit(`RVCB_SEL_CNT_RESET))  counter_reset_reg       <= shift_word;
            if (hit(`RVCB_SEL_R0))         power_cal_reg           <= shift_word;
            if (hit(`RVCB_SEL_R5))         int_frac_reg            <= shift_word;
        end
    end

    // ------------------------------------------------------------------
    // Outputs; the divide value is double buffered by the register five write
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (sync_reset) begin
            o_divide <= '0;
        end else if (hit(`RVCB_SEL_R5)) begin
            o_divide.int_value  <= shift_word[`RVCB_INT_HI:`RVCB_INT_LO];
            o_divide.frac_value <= {shift_word[`RVCB_FMSB_HI:`RVCB_FMSB_LO],
                                    fraction_low_reg[`RVCB_FLSB_HI:`RVCB_FLSB_LO]};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_refpath        <= '0;
            o_power_cal_ctrl <= `RVCB_WORD_RESET;
            o_setup_nine     <= `RVCB_WORD_RESET;
            o_setup_ten      <= `RVCB_WORD_RESET;
            o_counters_held  <= 1'b0;
            o_master_reset   <= 1'b0;
        end else begin
            o_refpath.ref_doubler           <= reset_reference_reg[`RVCB_DOUBLER_BIT];
            o_refpath.reference_half_divide <= reset_reference_reg[`RVCB_HALF_DIV_BIT];
            o_refpath.ref_divide  <= reset_reference_reg[`RVCB_RDIV_HI:`RVCB_RDIV_LO];
            o_refpath.cal_divider <= reset_reference_reg[`RVCB_CAL_DIV_HI:`RVCB_CAL_DIV_LO];
            o_refpath.cal_clock_divider <=
                cal_clock_divider_reg[`RVCB_CALCLK_HI:`RVCB_CALCLK_LO];
            o_power_cal_ctrl <= power_cal_reg;
            o_setup_nine     <= reserved_setup_nine_reg;
            o_setup_ten      <= reserved_setup_ten_reg;
            o_counters_held  <= counter_reset_reg[`RVCB_CNT_RESET_BIT];
            o_master_reset   <= master_reset;
        end
    end

    // ------------------------------------------------------------------
    // Reference path: optional doubler, 5-bit counter, optional toggle
    // ------------------------------------------------------------------
    // Doubling counts both reference edges; the reference must be well under mclk/4.
    logic       ref_tick;
    logic [4:0] ref_count;
    logic       ref_out;
    logic       half_toggle;
    logic       counters_held;

    assign counters_held = counter_reset_reg[`RVCB_CNT_RESET_BIT];
    assign ref_tick = reset_reference_reg[`RVCB_DOUBLER_BIT] ? ref_edge : ref_rise;

    always_ff @(posedge i_mclk) begin
        if (sync_reset || counters_held) begin
            ref_count <= 5'h00;
            ref_out   <= 1'b0;
        end else if (ref_tick) begin
            if (ref_count + 5'h01 >= reset_reference_reg[`RVCB_RDIV_HI:`RVCB_RDIV_LO]) begin
                ref_count <= 5'h00;
                ref_out   <= 1'b1;
            end else begin
                ref_count <= ref_count + 5'h01;
                ref_out   <= 1'b0;
            end
        end else begin
            ref_out <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sync_reset || counters_held) begin
            half_toggle     <= 1'b0;
            o_cal_reference <= 1'b0;
        end else begin
            if (ref_out) half_toggle <= ~half_toggle;
            o_cal_reference <= reset_reference_reg[`RVCB_HALF_DIV_BIT]
                             ? (ref_out & half_toggle) : ref_out;
        end
    end

endmodule // rvcb_bank
`default_nettype wire

// ==== hw/rvcb_defs.svh ====
// Field positions, select codes and reset values of the radar control register bank.
`ifndef RVCB_DEFS_SVH
`define RVCB_DEFS_SVH

`define RVCB_SEL_R0          5'h00
`define RVCB_SEL_R5          5'h05
`define RVCB_SEL_FRAC_LOW    5'h06
`define RVCB_SEL_RESET_REF   5'h07
`define RVCB_SEL_CAL_CLOCK   5'h08
`define RVCB_SEL_SETUP_NINE  5'h09
`define RVCB_SEL_SETUP_TEN   5'h0a
`define RVCB_SEL_CNT_RESET   5'h0b

`define RVCB_MASTER_RESET_BIT 25
`define RVCB_CAL_DIV_HI       23
`define RVCB_CAL_DIV_LO       12
`define RVCB_HALF_DIV_BIT     11
`define RVCB_DOUBLER_BIT      10
`define RVCB_RDIV_HI          9
`define RVCB_RDIV_LO          5
`define RVCB_CALCLK_HI        14
`define RVCB_CALCLK_LO        5
`define RVCB_CNT_RESET_BIT    5
`define RVCB_INT_HI           28
`define RVCB_INT_LO           17
`define RVCB_FMSB_HI          16
`define RVCB_FMSB_LO          5
`define RVCB_FLSB_HI          17
`define RVCB_FLSB_LO          5

`define RVCB_WORD_RESET       32'h0000_0000
`define RVCB_BITCNT_RESET     6'h00

`endif

// ==== hw/rvcb_pkg.sv ====
// Types shared by the radar control register bank.
`default_nettype none
package rvcb_pkg;
    typedef struct packed {
        logic [11:0] int_value;
        logic [24:0] frac_value;
    } rvcb_divide_s;

    typedef struct packed {
        logic        ref_doubler;
        logic        reference_half_divide;
        logic [4:0]  ref_divide;
        logic [11:0] cal_divider;
        logic [9:0]  cal_clock_divider;
    } rvcb_refpath_s;
endpackage
`default_nettype wire
